// ===== hw/cpu_seq_pkg.sv
package cpu_seq_pkg;

  // ==========================================================
  // Widths and register map
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam logic [3:0] OFF_SYS_CTRL = 4'h0;
  localparam logic [3:0] OFF_CCR = 4'h4;
  localparam logic [3:0] OFF_SP = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;

  // ==========================================================
  // Field positions and reset values
  localparam int STANDBY_SEL_BIT = 7;
  localparam int USER_MASK_EN_BIT = 3;
  localparam int CCR_I_BIT = 7;
  localparam int CCR_USER_IRQ_BIT = 6;
  localparam logic [7:0] SYS_CTRL_RST = 8'h0B;
  localparam logic [7:0] CCR_RST = 8'h80;
  localparam logic [23:0] SP_RST = 24'h000000;
  localparam logic [23:0] RESET_VEC = 24'h000000;
  localparam logic [23:0] MASK_1MB = 24'h0FFFFF;
  localparam logic [23:0] PUSH_BYTES = 24'h000004;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_EXEC = 3'b001,
    ST_EXC = 3'b010,
    ST_SLEEP = 3'b011,
    ST_SWSTBY = 3'b100,
    ST_HWSTBY = 3'b101
  } proc_state_type;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_PUSH = 2'b01,
    EX_FETCH = 2'b10
  } ex_step_type;

  typedef enum logic [1:0] {
    SRC_RESET = 2'b00,
    SRC_IRQ = 2'b01,
    SRC_TRAP = 2'b10
  } exc_src_type;

  typedef struct packed {
    logic req;
    logic we;
    logic [23:0] addr;
    logic [31:0] wdata;
  } mem_req_type;

  // ==========================================================
  // Address helpers
  function automatic logic [23:0] ea_fix(input logic [23:0] a,
                                         input logic wide,
                                         input logic mode_1mb);
    logic [23:0] r;
    r = mode_1mb ? (a & MASK_1MB) : a;
    if (wide) begin
      r[0] = 1'b0;
    end
    return r;
  endfunction

  function automatic logic [23:0] vec_addr(input logic [7:0] num);
    return {14'h0000, num, 2'b00};
  endfunction

endpackage

// ===== hw/ea_unit.sv
`timescale 1ns/1ps
module ea_unit (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [23:0] ea_raw_i,
  input wire logic ea_wide_i,
  input wire logic mode_1mb_i,
  output logic [23:0] ea_o
);

  logic [23:0] ea_q;
  logic [23:0] ea_d;

  // Odd word, longword or branch address starts at the even byte below
  always_comb begin
    ea_d = cpu_seq_pkg::ea_fix(ea_raw_i, ea_wide_i, mode_1mb_i);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ea_q <= 24'h000000;
    end else begin
      ea_q <= ea_d;
    end
  end

  assign ea_o = ea_q;

endmodule

// ===== hw/cpu_state_exception_seq.sv
// Added by the designer: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Odd word, longword or branch addresses have bit zero forced low.
// - In 1-Mbyte modes the top four address bits are dropped.
// - Core is in exactly one of four states; power-down has three modes.
// - Exceptions fetch a start address from the vector table and run there.
// - Priority is reset first, then interrupts, then traps.
// - A trap is always accepted in program execution when it executes.
// - Interrupts are sampled at instruction end or exception sequence end.
// - No interrupt after COND_CODE_REG and/or/xor/load or right after reset handling that follows a pin, watchdog or reset_i reset.
// - Reset pin low enters reset; its rise starts reset handling.
// - All interrupts including non-maskable held off during and after a pin, watchdog or reset_i reset.
// - Interrupt and trap handling push PC and COND_CODE_REG using the stack pointer.
// - After push set I; also set UI when user mask enable is clear.
// - Reset sets the I flag and masks all interrupts in reset state.
// - Watchdog overflow enters reset state just like the reset pin.
// - Sleep with standby select clear enters sleep, registers kept.
// - Sleep with standby select set enters software standby.
// - Standby pin low enters hardware standby, clock halted, modules reset.
// - Standby select is bit 7 of the system control register.
// - Every step is timed in states of one system clock period.
module cpu_state_exception_seq (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic hw_reset_pin_n_i,
  input wire logic hw_standby_pin_n_i,
  input wire logic mode_1mb_pin_i,
  input wire logic watchdog_ovf_i,
  input wire logic irq_req_i,
  input wire logic irq_nmi_i,
  input wire logic [7:0] irq_vec_i,
  input wire logic instr_end_i,
  input wire logic instr_ccr_op_i,
  input wire logic trap_i,
  input wire logic [7:0] trap_vec_i,
  input wire logic sleep_i,
  input wire logic [23:0] ea_raw_i,
  input wire logic ea_wide_i,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output cpu_seq_pkg::mem_req_type mem_o,
  output cpu_seq_pkg::proc_state_type state_o,
  output logic pc_load_o,
  output logic [23:0] pc_o,
  output logic irq_ack_o,
  output logic cpu_halt_o,
  output logic clk_halt_o,
  output logic module_reset_o,
  output logic [23:0] ea_o
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic rst_pin_n;
  logic standby_n;
  logic mode_1mb;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_meta_q <= 3'h3;
      pin_sync_q <= 3'h3;
    end else begin
      pin_meta_q <= {mode_1mb_pin_i, hw_standby_pin_n_i, hw_reset_pin_n_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign rst_pin_n = pin_sync_q[0];
  assign standby_n = pin_sync_q[1];
  assign mode_1mb = pin_sync_q[2];
  ea_unit i_ea_unit (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .ea_raw_i(ea_raw_i),
    .ea_wide_i(ea_wide_i),
    .mode_1mb_i(mode_1mb),
    .ea_o(ea_o)
  );

  // ==========================================================
  // Sequencer state
  cpu_seq_pkg::proc_state_type state_q, state_d;
  cpu_seq_pkg::ex_step_type step_q, step_d;
  cpu_seq_pkg::exc_src_type src_q, src_d;
  cpu_seq_pkg::mem_req_type mem_q, mem_d;
  logic [7:0] ccr_q, ccr_d;
  logic [7:0] sysctl_q, sysctl_d;
  logic [23:0] sp_q, sp_d;
  logic [23:0] pc_q, pc_d;
  logic [23:0] vec_q, vec_d;
  logic [7:0] tvec_q, tvec_d;
  logic rst_block_q, rst_block_d;
  logic trap_pend_q, trap_pend_d;
  logic pcload_q, pcload_d;
  logic irqack_q, irqack_d;
  logic [2:0] pwr_q, pwr_d;
  logic [31:0] rdat_q, rdat_d;
  logic ack_q, ack_d;
  logic wb_req;
  logic wb_wr;
  logic irq_ok;
  logic start_irq;
  logic start_trap;

  assign wb_req = wb_cyc_i && wb_stb_i;
  // Write lands on the edge after ack is shown to the master, while ack_q is high
  assign wb_wr = wb_req && wb_we_i && ack_q;
  assign irq_ok = irq_nmi_i || (irq_req_i && !ccr_q[cpu_seq_pkg::CCR_I_BIT]);

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    src_d = src_q;
    mem_d = mem_q;
    ccr_d = ccr_q;
    sysctl_d = sysctl_q;
    sp_d = sp_q;
    pc_d = pc_q;
    vec_d = vec_q;
    tvec_d = tvec_q;
    rst_block_d = rst_block_q;
    trap_pend_d = trap_pend_q;
    pcload_d = 1'b0;
    irqack_d = 1'b0;
    start_irq = 1'b0;
    start_trap = 1'b0;
    ack_d = wb_req && !ack_q;
    rdat_d = rdat_q;
    // Software writes come first so a hardware set below wins
    if (wb_wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        cpu_seq_pkg::OFF_SYS_CTRL: sysctl_d = wb_dat_i[7:0];
        cpu_seq_pkg::OFF_CCR: ccr_d = wb_dat_i[7:0];
        cpu_seq_pkg::OFF_SP: sp_d = wb_dat_i[23:0];
        default: ;
      endcase
    end
    if (wb_req && !ack_q) begin
      unique case (wb_adr_i)
        cpu_seq_pkg::OFF_SYS_CTRL: rdat_d = {24'h000000, sysctl_q};
        cpu_seq_pkg::OFF_CCR: rdat_d = {24'h000000, ccr_q};
        cpu_seq_pkg::OFF_SP: rdat_d = {8'h00, sp_q};
        cpu_seq_pkg::OFF_STATUS: rdat_d = {29'h00000000, state_q};
        default: rdat_d = 32'h00000000;
      endcase
    end
    if (!standby_n) begin
      state_d = cpu_seq_pkg::ST_HWSTBY;
      step_d = cpu_seq_pkg::EX_IDLE;
      mem_d.req = 1'b0;
    end else if (!rst_pin_n || watchdog_ovf_i) begin
      state_d = cpu_seq_pkg::ST_RESET;
      step_d = cpu_seq_pkg::EX_IDLE;
      mem_d.req = 1'b0;
      ccr_d[cpu_seq_pkg::CCR_I_BIT] = 1'b1;
      rst_block_d = 1'b1;
      trap_pend_d = 1'b0;
    end else begin
      unique case (state_q)
        cpu_seq_pkg::ST_HWSTBY: begin
          state_d = cpu_seq_pkg::ST_RESET;
        end
        cpu_seq_pkg::ST_RESET: begin
          // Reset pin is high again: start reset handling now
          state_d = cpu_seq_pkg::ST_EXC;
          src_d = cpu_seq_pkg::SRC_RESET;
          step_d = cpu_seq_pkg::EX_FETCH;
          vec_d = cpu_seq_pkg::RESET_VEC;
          mem_d = '{1'b1, 1'b0, cpu_seq_pkg::RESET_VEC, 32'h00000000};
        end
        cpu_seq_pkg::ST_EXEC: begin
          if (trap_i) begin
            trap_pend_d = 1'b1;
            tvec_d = trap_vec_i;
          end
          if (instr_end_i) begin
            rst_block_d = 1'b0;
            if (irq_ok && !instr_ccr_op_i && !rst_block_q) begin
              start_irq = 1'b1;
            end else if (trap_i || trap_pend_q) begin
              start_trap = 1'b1;
            end else if (sleep_i) begin
              state_d = sysctl_q[cpu_seq_pkg::STANDBY_SEL_BIT] ?
                cpu_seq_pkg::ST_SWSTBY : cpu_seq_pkg::ST_SLEEP;
            end
          end
        end
        cpu_seq_pkg::ST_SLEEP: begin
          start_irq = irq_ok;
        end
        cpu_seq_pkg::ST_SWSTBY: begin
          // Standby select stays set after wake-up
          start_irq = irq_nmi_i || irq_req_i;
        end
        cpu_seq_pkg::ST_EXC: begin
          if (mem_ack_i && step_q == cpu_seq_pkg::EX_PUSH) begin
            sp_d = sp_q - cpu_seq_pkg::PUSH_BYTES;
            ccr_d[cpu_seq_pkg::CCR_I_BIT] = 1'b1;
            if (!sysctl_q[cpu_seq_pkg::USER_MASK_EN_BIT]) begin
              ccr_d[cpu_seq_pkg::CCR_USER_IRQ_BIT] = 1'b1;
            end
            step_d = cpu_seq_pkg::EX_FETCH;
            mem_d = '{1'b1, 1'b0, vec_q, 32'h00000000};
          end else if (mem_ack_i && step_q == cpu_seq_pkg::EX_FETCH) begin
            pc_d = cpu_seq_pkg::ea_fix(mem_rdata_i[23:0], 1'b1, mode_1mb);
            pcload_d = 1'b1;
            mem_d.req = 1'b0;
            step_d = cpu_seq_pkg::EX_IDLE;
            state_d = cpu_seq_pkg::ST_EXEC;
            // Chained interrupt at sequence end, never right after reset
            start_irq = src_q != cpu_seq_pkg::SRC_RESET && irq_ok;
          end
        end
        default: begin
          state_d = cpu_seq_pkg::ST_RESET;
        end
      endcase
      if (start_irq || start_trap) begin
        state_d = cpu_seq_pkg::ST_EXC;
        step_d = cpu_seq_pkg::EX_PUSH;
        src_d = start_irq ? cpu_seq_pkg::SRC_IRQ : cpu_seq_pkg::SRC_TRAP;
        vec_d = cpu_seq_pkg::vec_addr(start_irq ? irq_vec_i : (trap_i ?
                                      trap_vec_i : tvec_q));
        irqack_d = start_irq;
        trap_pend_d = start_irq && (trap_i || trap_pend_q);
        mem_d = '{1'b1, 1'b1, sp_q - cpu_seq_pkg::PUSH_BYTES,
                  {ccr_q, pc_d}};
      end
    end
    pwr_d[0] = state_d != cpu_seq_pkg::ST_EXEC &&
               state_d != cpu_seq_pkg::ST_EXC;
    pwr_d[1] = state_d == cpu_seq_pkg::ST_SWSTBY ||
               state_d == cpu_seq_pkg::ST_HWSTBY;
    pwr_d[2] = pwr_d[1] || state_d == cpu_seq_pkg::ST_RESET;
  end

  // Each register step is one state of the system clock
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= cpu_seq_pkg::ST_RESET;
      step_q <= cpu_seq_pkg::EX_IDLE;
      src_q <= cpu_seq_pkg::SRC_RESET;
      mem_q <= '0;
      ccr_q <= cpu_seq_pkg::CCR_RST;
      sysctl_q <= cpu_seq_pkg::SYS_CTRL_RST;
      sp_q <= cpu_seq_pkg::SP_RST;
      pc_q <= 24'h000000;
      vec_q <= 24'h000000;
      tvec_q <= 8'h00;
      rst_block_q <= 1'b1;
      trap_pend_q <= 1'b0;
      pcload_q <= 1'b0;
      irqack_q <= 1'b0;
      pwr_q <= 3'h5;
      rdat_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      step_q <= step_d;
      src_q <= src_d;
      mem_q <= mem_d;
      ccr_q <= ccr_d;
      sysctl_q <= sysctl_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      vec_q <= vec_d;
      tvec_q <= tvec_d;
      rst_block_q <= rst_block_d;
      trap_pend_q <= trap_pend_d;
      pcload_q <= pcload_d;
      irqack_q <= irqack_d;
      pwr_q <= pwr_d;
      rdat_q <= rdat_d;
      ack_q <= ack_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign mem_o = mem_q;
  assign state_o = state_q;
  assign pc_load_o = pcload_q;
  assign pc_o = pc_q;
  assign irq_ack_o = irqack_q;
  assign cpu_halt_o = pwr_q[0];
  assign clk_halt_o = pwr_q[1];
  assign module_reset_o = pwr_q[2];

  // ==========================================================
  // Checks
  sequence push_done_s;
    state_q == cpu_seq_pkg::ST_EXC && step_q == cpu_seq_pkg::EX_PUSH &&
    mem_ack_i && standby_n && rst_pin_n && !watchdog_ovf_i;
  endsequence

  sequence fetch_done_s;
    state_q == cpu_seq_pkg::ST_EXC && step_q == cpu_seq_pkg::EX_FETCH &&
    mem_ack_i && standby_n && rst_pin_n && !watchdog_ovf_i;
  endsequence

  ea_align_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ea_wide_i |=> ea_o[0] == 1'b0) else $error("odd wide address");
  ea_mask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mode_1mb |=> ea_o[23:20] == 4'h0) else $error("upper bits kept");
  one_state_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state_q inside {cpu_seq_pkg::ST_RESET, cpu_seq_pkg::ST_EXEC,
    cpu_seq_pkg::ST_EXC, cpu_seq_pkg::ST_SLEEP, cpu_seq_pkg::ST_SWSTBY,
    cpu_seq_pkg::ST_HWSTBY}) else $error("illegal state");
  vec_fetch_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    fetch_done_s |=> pc_load_o && pc_o[0] == 1'b0 &&
    state_q inside {cpu_seq_pkg::ST_EXEC, cpu_seq_pkg::ST_EXC})
    else $error("no return after vector fetch");
  mask_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    push_done_s |=> ccr_q[cpu_seq_pkg::CCR_I_BIT] &&
    (sysctl_q[cpu_seq_pkg::USER_MASK_EN_BIT] ||
    ccr_q[cpu_seq_pkg::CCR_USER_IRQ_BIT]) &&
    step_q == cpu_seq_pkg::EX_FETCH) else $error("mask flags not set");
  reset_pin_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    standby_n && !rst_pin_n |=> state_q == cpu_seq_pkg::ST_RESET &&
    ccr_q[cpu_seq_pkg::CCR_I_BIT]) else $error("reset not entered");
  reset_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rst_block_q && state_q != cpu_seq_pkg::ST_SLEEP &&
    state_q != cpu_seq_pkg::ST_SWSTBY |=> !irq_ack_o)
    else $error("interrupt during reset");
  push_first_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    irq_ack_o |-> mem_o.req && mem_o.we && mem_o.addr == sp_q -
    cpu_seq_pkg::PUSH_BYTES) else $error("no stack push");
  sleep_entry_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state_q == cpu_seq_pkg::ST_SLEEP |-> cpu_halt_o && !clk_halt_o)
    else $error("sleep outputs wrong");
  trap_take_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    state_q == cpu_seq_pkg::ST_EXEC && instr_end_i && trap_i && standby_n &&
    rst_pin_n && !watchdog_ovf_i |=> state_q == cpu_seq_pkg::ST_EXC)
    else $error("trap not taken");

endmodule

// ===== verification/mem_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Memory side: answers each request after delay_i wait cycles
module mem_partner (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire cpu_seq_pkg::mem_req_type mem_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [31:0] rdata_o,
  output logic [23:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [23:0] rd_addr_o
);
  logic [3:0] cnt;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      rdata_o <= 32'h5A5A5A5A;
      wr_addr_o <= 24'h000000;
      wr_data_o <= 32'h00000000;
      rd_addr_o <= 24'h000000;
    end else if (ack_o) begin
      ack_o <= 1'b0;
      cnt <= 4'h0;
      // Released data flips so a late sample never looks valid
      rdata_o <= ~rdata_o;
    end else if (mem_i.req && cnt == delay_i) begin
      ack_o <= 1'b1;
      if (mem_i.we) begin
        wr_addr_o <= mem_i.addr;
        wr_data_o <= mem_i.wdata;
      end else begin
        rd_addr_o <= mem_i.addr;
        // Odd start addresses exercise the alignment path
        rdata_o <= {8'hEE, 4'hA, mem_i.addr[19:0] + 20'h01001};
      end
    end else begin
      if (mem_i.req) begin
        cnt <= cnt + 4'h1;
      end
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ===== verification/tb_cpu_state_exception_seq.sv
`timescale 1ns/1ps
module tb_cpu_state_exception_seq;
  logic ref_clk_i, reset_i, rst_n, standby_n, m1mb, wdt, irq, nmi, iend;
  logic ccr_op, trap, sleep, wide, cyc, stb, we, mack, wack, pcl, iack;
  logic chalt, khalt, mrst;
  logic [7:0] ivec, tvec;
  logic [3:0] adr, sel, mdly;
  logic [23:0] ea_raw, ea, pc, wra, rda;
  logic [31:0] wdw, wdr, mrd, wrd, q;
  cpu_seq_pkg::mem_req_type mreq;
  cpu_seq_pkg::proc_state_type st;
  int bad_count, check_count, cycles, acks;

  cpu_state_exception_seq i_cpu_state_exception_seq (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .hw_reset_pin_n_i(rst_n),
    .hw_standby_pin_n_i(standby_n),
    .mode_1mb_pin_i(m1mb), .watchdog_ovf_i(wdt), .irq_req_i(irq),
    .irq_nmi_i(nmi), .irq_vec_i(ivec), .instr_end_i(iend),
    .instr_ccr_op_i(ccr_op), .trap_i(trap), .trap_vec_i(tvec),
    .sleep_i(sleep), .ea_raw_i(ea_raw), .ea_wide_i(wide), .mem_ack_i(mack),
    .mem_rdata_i(mrd), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdw), .wb_dat_o(wdr),
    .wb_ack_o(wack), .mem_o(mreq), .state_o(st), .pc_load_o(pcl),
    .pc_o(pc), .irq_ack_o(iack), .cpu_halt_o(chalt), .clk_halt_o(khalt),
    .module_reset_o(mrst), .ea_o(ea));
  mem_partner i_mem_partner (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .mem_i(mreq), .delay_i(mdly), .ack_o(mack), .rdata_o(mrd),
    .wr_addr_o(wra), .wr_data_o(wrd), .rd_addr_o(rda));

  // ==========================================================
  // Clock, timeout and the interrupt controller's level release
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (iack === 1'b1) begin
      acks++;
      irq <= 1'b0;
      nmi <= 1'b0;
    end
    if (cycles >= 20000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdw <= d;
    // Only the bench timeout ends the wait for the answer
    do begin
      @(posedge ref_clk_i);
    end while (wack !== 1'b1);
    q = wdr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000);
    check(q, exp);
  endtask
  task automatic wait_st(input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    while (st !== exp && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
    check(st, exp);
  endtask
  // Waits for the start address load and checks where it came from
  task automatic wait_pc(input logic [23:0] va);
    int n;
    logic [23:0] e;
    e = {4'hA, va[19:0] + 20'h01001};
    e[0] = 1'b0;
    if (m1mb) begin
      e = e & 24'h0FFFFF;
    end
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pcl !== 1'b1 && n < 200);
    check(pcl, 1'b1);
    check(pc, e);
    check(rda, va);
    check(st, cpu_seq_pkg::ST_EXEC);
  endtask
  task automatic pulse_end(input logic op, input logic tr, input logic sl,
                           input int exp);
    int a0;
    @(posedge ref_clk_i);
    a0 = acks;
    iend <= 1'b1;
    ccr_op <= op;
    trap <= tr;
    sleep <= sl;
    @(posedge ref_clk_i);
    iend <= 1'b0;
    ccr_op <= 1'b0;
    trap <= 1'b0;
    sleep <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    if (exp >= 0) begin
      check(acks - a0, exp);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    wait_pc(24'h000000);
    pulse_end(1'b0, 1'b0, 1'b0, 0);
    pulse_end(1'b0, 1'b0, 1'b0, 1);
    wait_pc(24'h000070);
    rd(4'h0, 32'h0000000B);
    rd(4'h4, 32'h00000080);
    rd(4'hC, 32'h00000001);
    wb(1'b1, 4'h2, 32'h000000FF);
    rd(4'h2, 32'h00000000);
  endtask
  task automatic t_irq(input logic [7:0] sys, input logic [7:0] cond_code_reg,
                       input logic [3:0] dly);
    logic [23:0] p;
    mdly <= dly;
    wb(1'b1, 4'h0, {24'h000000, sys});
    wb(1'b1, 4'h8, 32'h00000100);
    wb(1'b1, 4'h4, 32'h00000000);
    p = pc;
    ivec <= 8'h30;
    irq <= 1'b1;
    pulse_end(1'b1, 1'b0, 1'b0, 0);
    pulse_end(1'b0, 1'b0, 1'b0, 1);
    wait_pc(24'h0000C0);
    check(wra, 24'h0000FC);
    check(wrd, {8'h00, p});
    rd(4'h4, {24'h000000, cond_code_reg});
    rd(4'h8, 32'h000000FC);
    irq <= 1'b1;
    pulse_end(1'b0, 1'b0, 1'b0, 0);
    irq <= 1'b0;
  endtask
  task automatic t_trap();
    tvec <= 8'h08;
    pulse_end(1'b0, 1'b1, 1'b0, -1);
    wait_pc(24'h000020);
    check(wra, 24'h0000F8);
    wb(1'b1, 4'h4, 32'h00000000);
    irq <= 1'b1;
    pulse_end(1'b0, 1'b1, 1'b0, 1);
    wait_pc(24'h0000C0);
    // The trap that lost to the interrupt is taken at the next boundary
    pulse_end(1'b0, 1'b0, 1'b0, 0);
    wait_pc(24'h000020);
    check(wra, 24'h0000F0);
  endtask
  task automatic t_ea();
    logic [23:0] r[4] = '{24'hF12345, 24'hF12345, 24'hF12345, 24'hABCDE7};
    logic [23:0] x[4] = '{24'hF12344, 24'hF12345, 24'h012344, 24'h0BCDE7};
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      m1mb <= (i >= 2);
      ea_raw <= r[i];
      wide <= (i != 1 && i != 3);
      repeat (5) @(posedge ref_clk_i);
      check(ea, x[i]);
    end
  endtask
  task automatic t_pin_reset();
    // Clear the flags first so the reset visibly sets the mask bit
    wb(1'b1, 4'h4, 32'h00000000);
    rst_n <= 1'b0;
    wait_st(cpu_seq_pkg::ST_RESET, 4);
    check({chalt, mrst}, 32'h00000003);
    repeat (4) @(posedge ref_clk_i);
    rst_n <= 1'b1;
    wait_pc(24'h000000);
    rd(4'h4, 32'h00000080);
    wdt <= 1'b1;
    wait_st(cpu_seq_pkg::ST_RESET, 3);
    wdt <= 1'b0;
    wait_pc(24'h000000);
  endtask
  task automatic t_sleep(input logic [7:0] sys, input logic [2:0] exp);
    wb(1'b1, 4'h0, {24'h000000, sys});
    pulse_end(1'b0, 1'b0, 1'b1, 0);
    wait_st(exp, 3);
    check({chalt, khalt, mrst}, {29'h0, 1'b1, sys[7], sys[7]});
    ivec <= 8'h1C;
    nmi <= 1'b1;
    wait_pc(24'h000070);
  endtask
  task automatic t_hwstby();
    standby_n <= 1'b0;
    wait_st(cpu_seq_pkg::ST_HWSTBY, 4);
    check({khalt, mrst}, 32'h00000003);
    standby_n <= 1'b1;
    wait_pc(24'h000000);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {reset_i, rst_n, standby_n} = 3'b111;
    {m1mb, wdt, irq, iend, ccr_op, trap, sleep, wide} = 8'h00;
    {cyc, stb, we} = 3'b000;
    nmi = 1'b1;
    ivec = 8'h1C;
    tvec = 8'h00;
    adr = 4'h0;
    sel = 4'hF;
    mdly = 4'h0;
    ea_raw = 24'h000000;
    wdw = 32'h00000000;
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_irq(8'h0B, 8'h80, 4'h0);
    t_irq(8'h03, 8'hC0, 4'h3);
    t_trap();
    t_ea();
    t_pin_reset();
    t_sleep(8'h0B, cpu_seq_pkg::ST_SLEEP);
    t_sleep(8'h8B, cpu_seq_pkg::ST_SWSTBY);
    t_hwstby();
    results();
  end
endmodule
